//--- core/dfpi_host_if.v
// host bus interface of a two-function bus-mastering controller
// assumes pin levels arrive asynchronous; sequencer events are on clk
`timescale 1ns/100ps
`default_nettype none
`include "dfpi_map.vh"
module dfpi_host_if (
  input wire clk,
  input wire reset,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // arbitration pins
  output reg scsi_bus_request,
  input wire scsi_bus_grant,
  output reg net_bus_request,
  input wire net_bus_grant,
  // configuration selects and address phase
  input wire scsi_config_select,
  input wire net_config_select,
  input wire addr_phase,
  input wire bus_idle,
  input wire [3:0] cbe_in,
  output reg scsi_cfg_hit,
  output reg net_cfg_hit,
  // parking drive of the shared lines
  output reg [31:0] ad_out,
  output reg ad_oe,
  output reg [3:0] cbe_out,
  output reg cbe_oe,
  output reg par_out,
  output reg par_oe,
  // events from the function sequencers
  input wire scsi_dma_want,
  input wire net_dma_want,
  input wire scsi_dma_done,
  input wire net_event,
  input wire scsi_target_abort,
  input wire scsi_master_abort,
  input wire net_target_abort,
  input wire net_master_abort,
  output reg dma_running,
  output reg dma_flushing,
  // open-drain interrupt pins
  output wire scsi_int_out,
  output wire scsi_int_oe,
  output wire net_int_out,
  output wire net_int_oe
);
  // ------------------------------------------------------------
  // dma states
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_RUN = 2'b01;
  localparam ST_FLUSH = 2'b10;

  reg [1:0] dma_state_r;
  reg [1:0] dma_state_nxt;
  reg dma_abort_r;
  reg scsi_rta_r;
  reg scsi_rma_r;
  reg net_rta_r;
  reg net_rma_r;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_mask_r;
  reg [7:0] net_int_pin_r;
  reg ready_r;
  reg [31:0] rd_mux;
  reg rd_err;

  wire scsi_gnt_s;
  wire net_gnt_s;
  wire scsi_sel_s;
  wire net_sel_s;
  wire addr_s;
  wire idle_s;
  wire [3:0] cbe_s;
  wire [9:0] pin_raw;
  wire [9:0] pin_s;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  assign pin_raw = {cbe_in, bus_idle, addr_phase, net_config_select,
                    scsi_config_select, net_bus_grant, scsi_bus_grant};
  dfpi_sync #(.W(10)) u_sync (
    .clk(clk),
    .reset(reset),
    .d(pin_raw),
    .q(pin_s)
  );
  assign scsi_gnt_s = pin_s[0];
  assign net_gnt_s = pin_s[1];
  assign scsi_sel_s = pin_s[2];
  assign net_sel_s = pin_s[3];
  assign addr_s = pin_s[4];
  assign idle_s = pin_s[5];
  assign cbe_s = pin_s[9:6];

  // ------------------------------------------------------------
  // apb access decode
  // ------------------------------------------------------------
  // one wait state so that read data comes from a flip-flop
  wire acc = psel & penable;
  wire done = acc & ready_r;
  wire wr_done = done & pwrite;
  wire rd_done = done & ~pwrite;
  wire cmd_wr = wr_done & (paddr == `DFPI_OFS_DMA_CMD);
  wire [1:0] cmd = pwdata[1:0];
  wire irq_rd = rd_done & (paddr == `DFPI_OFS_IRQ_STAT);
  wire scsi_cs_wr = wr_done & (paddr == `DFPI_OFS_SCSI_CFG_STAT);
  wire net_cs_wr = wr_done & (paddr == `DFPI_OFS_NET_CFG_STAT);
  assign pready = ready_r;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `DFPI_OFS_SCSI_CFG_STAT:
      begin
        rd_mux[`DFPI_BIT_RX_TABORT] = scsi_rta_r;
        rd_mux[`DFPI_BIT_RX_MABORT] = scsi_rma_r;
      end
      `DFPI_OFS_NET_CFG_STAT:
      begin
        rd_mux[`DFPI_BIT_RX_TABORT] = net_rta_r;
        rd_mux[`DFPI_BIT_RX_MABORT] = net_rma_r;
      end
      `DFPI_OFS_NET_INT_PIN: rd_mux[7:0] = net_int_pin_r;
      `DFPI_OFS_DMA_CMD: rd_mux[1:0] = dma_state_r;
      `DFPI_OFS_DMA_STAT:
      begin
        rd_mux[1:0] = dma_state_r;
        rd_mux[`DFPI_BIT_DMA_ABORT] = dma_abort_r;
      end
      `DFPI_OFS_IRQ_STAT: rd_mux[1:0] = irq_stat_r;
      `DFPI_OFS_IRQ_MASK: rd_mux[1:0] = irq_mask_r;
      default: rd_err = 1'b1;
    endcase
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ready_r <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      ready_r <= acc & ~ready_r;
      if (acc & ~ready_r)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= rd_err;
      end
      else if (~acc)
      begin
        pslverr <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // dma command decode and state
  // ------------------------------------------------------------
  wire scsi_abort_ev = scsi_target_abort | scsi_master_abort;

  always @*
  begin
    dma_state_nxt = dma_state_r;
    case (dma_state_r)
      ST_IDLE: dma_state_nxt = ST_IDLE;
      ST_RUN:
      begin
        if (scsi_abort_ev | scsi_dma_done)
          dma_state_nxt = ST_IDLE;
      end
      // flush drains for a single cycle, then rests
      ST_FLUSH: dma_state_nxt = ST_IDLE;
      default: dma_state_nxt = ST_IDLE;
    endcase
    if (cmd_wr)
    begin
      case (cmd)
        `DFPI_CMD_IDLE: dma_state_nxt = ST_IDLE;
        `DFPI_CMD_FLUSH: dma_state_nxt = ST_FLUSH;
        `DFPI_CMD_START: dma_state_nxt = ST_RUN;
        `DFPI_CMD_ABORT: dma_state_nxt = ST_IDLE;
        default: dma_state_nxt = ST_IDLE;
      endcase
    end
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dma_state_r <= ST_IDLE;
      dma_abort_r <= 1'b0;
      dma_running <= 1'b0;
      dma_flushing <= 1'b0;
    end
    else
    begin
      dma_state_r <= dma_state_nxt;
      dma_running <= (dma_state_nxt == ST_RUN);
      dma_flushing <= (dma_state_nxt == ST_FLUSH);
      // disk aborts and the abort command raise the flag; set wins over the start-command clear
      if (scsi_abort_ev | (cmd_wr & (cmd == `DFPI_CMD_ABORT)))
        dma_abort_r <= 1'b1;
      else if (cmd_wr & (cmd == `DFPI_CMD_START))
        dma_abort_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // per-function configuration status
  // ------------------------------------------------------------
  // write one to clear; a same-cycle abort keeps the bit set
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scsi_rta_r <= 1'b0;
      scsi_rma_r <= 1'b0;
      net_rta_r <= 1'b0;
      net_rma_r <= 1'b0;
      net_int_pin_r <= `DFPI_NET_INT_PIN_RST;
    end
    else
    begin
      scsi_rta_r <= scsi_target_abort |
        (scsi_rta_r & ~(scsi_cs_wr & pwdata[`DFPI_BIT_RX_TABORT]));
      net_rta_r <= net_target_abort |
        (net_rta_r & ~(net_cs_wr & pwdata[`DFPI_BIT_RX_TABORT]));
      scsi_rma_r <= scsi_master_abort |
        (scsi_rma_r & ~(scsi_cs_wr & pwdata[`DFPI_BIT_RX_MABORT]));
      net_rma_r <= net_master_abort |
        (net_rma_r & ~(net_cs_wr & pwdata[`DFPI_BIT_RX_MABORT]));
    end
  end

  // ------------------------------------------------------------
  // configuration cycle claim
  // ------------------------------------------------------------
  wire cfg_cmd = addr_s &
    ((cbe_s == `DFPI_BUS_CFG_RD) | (cbe_s == `DFPI_BUS_CFG_WR));

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scsi_cfg_hit <= 1'b0;
      net_cfg_hit <= 1'b0;
    end
    else
    begin
      scsi_cfg_hit <= cfg_cmd & scsi_sel_s;
      net_cfg_hit <= cfg_cmd & net_sel_s;
    end
  end

  // ------------------------------------------------------------
  // arbitration and parking
  // ------------------------------------------------------------
  // the disk grant is read only for parking, the net grant only in a request term that ignores it; the sequencers see them elsewhere
  wire park = idle_s & scsi_gnt_s & ~scsi_bus_request;

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scsi_bus_request <= 1'b0;
      net_bus_request <= 1'b0;
      ad_out <= `DFPI_PARK_AD;
      cbe_out <= `DFPI_PARK_CBE;
      par_out <= 1'b0;
      ad_oe <= 1'b0;
      cbe_oe <= 1'b0;
      par_oe <= 1'b0;
    end
    else
    begin
      scsi_bus_request <= scsi_dma_want & (dma_state_nxt == ST_RUN);
      net_bus_request <= net_dma_want & ~net_gnt_s | net_dma_want;
      ad_out <= `DFPI_PARK_AD;
      cbe_out <= `DFPI_PARK_CBE;
      par_out <= ^{`DFPI_PARK_AD, `DFPI_PARK_CBE};
      ad_oe <= park;
      cbe_oe <= park;
      par_oe <= park;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  // aborts are not sources here, so they never pull a line low
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irq_stat_r <= 2'b00;
      irq_mask_r <= 2'b00;
    end
    else
    begin
      irq_stat_r[`DFPI_IRQ_BIT_SCSI] <= (scsi_dma_done & (dma_state_r == ST_RUN)) |
        (irq_stat_r[`DFPI_IRQ_BIT_SCSI] & ~irq_rd);
      irq_stat_r[`DFPI_IRQ_BIT_NET] <= net_event |
        (irq_stat_r[`DFPI_IRQ_BIT_NET] & ~irq_rd);
      if (wr_done & (paddr == `DFPI_OFS_IRQ_MASK))
        irq_mask_r <= pwdata[1:0];
    end
  end

  wire [1:0] irq_act = irq_stat_r & irq_mask_r;
  assign scsi_int_out = 1'b0;
  assign net_int_out = 1'b0;
  assign scsi_int_oe = irq_act[`DFPI_IRQ_BIT_SCSI];
  assign net_int_oe = irq_act[`DFPI_IRQ_BIT_NET];

endmodule // dfpi_host_if
`default_nettype wire

//--- core/dfpi_map.vh
// constants of the dual-function bus interface: offsets, fields, codes
// assumes inclusion by bare name from core/ design files only
`ifndef DFPI_MAP_VH
`define DFPI_MAP_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DFPI_OFS_SCSI_CFG_STAT 8'h00
`define DFPI_OFS_NET_CFG_STAT 8'h04
`define DFPI_OFS_NET_INT_PIN 8'h08
`define DFPI_OFS_DMA_CMD 8'h50
`define DFPI_OFS_DMA_STAT 8'h54
`define DFPI_OFS_IRQ_STAT 8'h58
`define DFPI_OFS_IRQ_MASK 8'h5c
// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define DFPI_BIT_RX_TABORT 12
`define DFPI_BIT_RX_MABORT 13
`define DFPI_BIT_DMA_ABORT 2
`define DFPI_NET_INT_PIN_RST 8'h02
`define DFPI_IRQ_BIT_SCSI 0
`define DFPI_IRQ_BIT_NET 1
// ------------------------------------------------------------
// dma commands, bus command codes and park drive values
// ------------------------------------------------------------
`define DFPI_CMD_IDLE 2'h0
`define DFPI_CMD_FLUSH 2'h1
`define DFPI_CMD_START 2'h2
`define DFPI_CMD_ABORT 2'h3
`define DFPI_BUS_CFG_RD 4'ha
`define DFPI_BUS_CFG_WR 4'hb
`define DFPI_PARK_AD 32'h0000_0000
`define DFPI_PARK_CBE 4'h0
`endif

//--- core/dfpi_sync.v
// two-stage synchroniser for a group of pin levels
// assumes the inputs are levels from outside the clk domain
`timescale 1ns/100ps
`default_nettype none
module dfpi_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire reset,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule // dfpi_sync
`default_nettype wire

//--- tb/dfpi_bus_model.sv
// far side of the host bus: arbiter and idle indication
// assumes requests are registered levels on clk
`timescale 1ns/100ps
`default_nettype none
module dfpi_bus_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic park_en,
  input wire logic scsi_bus_request,
  input wire logic net_bus_request,
  output logic scsi_bus_grant,
  output logic net_bus_grant,
  output logic bus_idle
);
  // disk side wins ties so one grant only; park on disk side when asked
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scsi_bus_grant <= 1'h0;
      net_bus_grant <= 1'h0;
      bus_idle <= 1'h0;
    end
    else
    begin
      scsi_bus_grant <= scsi_bus_request | (park_en & ~net_bus_request);
      net_bus_grant <= net_bus_request & ~scsi_bus_request;
      bus_idle <= ~(scsi_bus_request | net_bus_request);
    end
  end
endmodule // dfpi_bus_model
`default_nettype wire

//--- tb/dfpi_host_if_assertions.sv
// timing checks on the host interface pins
// assumes one clk domain, reset asynchronous and active high
`timescale 1ns/100ps
`default_nettype none
module dfpi_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic scsi_bus_request,
  input wire logic scsi_bus_grant,
  input wire logic bus_idle,
  input wire logic scsi_config_select,
  input wire logic addr_phase,
  input wire logic [3:0] cbe_in,
  input wire logic scsi_cfg_hit,
  input wire logic [31:0] ad_out,
  input wire logic ad_oe,
  input wire logic cbe_oe,
  input wire logic par_oe,
  input wire logic scsi_dma_done,
  input wire logic scsi_target_abort,
  input wire logic scsi_master_abort,
  input wire logic dma_running,
  input wire logic dma_flushing,
  input wire logic scsi_int_out,
  input wire logic scsi_int_oe,
  input wire logic net_int_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire cmd_wr = psel && penable && pready && pwrite && paddr == 8'h50;
  wire sabort = scsi_target_abort || scsi_master_abort;
  property p_open_drain; !scsi_int_out && !net_int_out; endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("interrupt pin driven high");
  // pins pass two sync stages and the drive register: three edges back
  property p_park;
    ad_oe |-> cbe_oe && par_oe && ad_out == 32'h0
      && $past(scsi_bus_grant, 3) && $past(bus_idle, 3);
  endproperty
  a_park: assert property (p_park)
    else $error("parked lines not all driven");
  property p_req_run; scsi_bus_request |-> dma_running; endproperty
  a_req_run: assert property (p_req_run)
    else $error("disk request outside a run");
  property p_halt; sabort && dma_running |=> !dma_running; endproperty
  a_halt: assert property (p_halt)
    else $error("abort did not halt the run");
  property p_quiet; sabort && !scsi_dma_done && !psel |=> !$rose(scsi_int_oe); endproperty
  a_quiet: assert property (p_quiet)
    else $error("abort raised the disk interrupt");
  property p_idle; cmd_wr && pwdata[1:0] == 2'h0 |-> ##2 !dma_running && !dma_flushing; endproperty
  a_idle: assert property (p_idle)
    else $error("idle command left block busy");
  property p_flush; cmd_wr && pwdata[1:0] == 2'h1 |-> ##[1:2] dma_flushing ##1 !dma_flushing;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush did not last one cycle");
  property p_cfg;
    scsi_cfg_hit |-> $past(scsi_config_select, 3) && $past(addr_phase, 3)
      && $past(cbe_in[3:1], 3) == 3'h5;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config hit without config cycle");
endmodule // dfpi_chk
bind dfpi_host_if dfpi_chk u_chk (
  .clk(clk),
  .reset(reset),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .scsi_bus_request(scsi_bus_request),
  .scsi_bus_grant(scsi_bus_grant),
  .bus_idle(bus_idle),
  .scsi_config_select(scsi_config_select),
  .addr_phase(addr_phase),
  .cbe_in(cbe_in),
  .scsi_cfg_hit(scsi_cfg_hit),
  .ad_out(ad_out),
  .ad_oe(ad_oe),
  .cbe_oe(cbe_oe),
  .par_oe(par_oe),
  .scsi_dma_done(scsi_dma_done),
  .scsi_target_abort(scsi_target_abort),
  .scsi_master_abort(scsi_master_abort),
  .dma_running(dma_running),
  .dma_flushing(dma_flushing),
  .scsi_int_out(scsi_int_out),
  .scsi_int_oe(scsi_int_oe),
  .net_int_out(net_int_out)
);
`default_nettype wire

//--- tb/dual_function_pci_host_interface_tb_top.sv
// self-checking bench of the two-function host bus interface
// assumes the checker binds itself; one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t got %h want %h", $time, (a), (e)); end end
module dual_function_pci_host_interface_tb_top;
  localparam logic RD = 1'h0, WR = 1'h1;
  logic clk = 1'h0, reset, psel, penable, pwrite, park_en, addr_phase;
  logic scsi_config_select, net_config_select, scsi_dma_want, net_dma_want;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] cbe_in;
  logic [5:0] ev;
  logic [32:0] exp_v, exp_q[$];
  logic [15:0] rnd = 16'h3133, cmds = 16'h26ba;
  int mismatches = 0, checks = 0;
  wire scsi_dma_done = ev[5], net_event = ev[4], scsi_target_abort = ev[3];
  wire scsi_master_abort = ev[2], net_target_abort = ev[1], net_master_abort = ev[0];
  wire [31:0] prdata, ad_out;
  wire [3:0] cbe_out;
  wire pready, pslverr, scsi_bus_request, net_bus_request, scsi_bus_grant, net_bus_grant;
  wire bus_idle, scsi_cfg_hit, net_cfg_hit, ad_oe, cbe_oe, par_oe, par_out, dma_running;
  wire dma_flushing, scsi_int_out, scsi_int_oe, net_int_out, net_int_oe;
  dfpi_host_if dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .scsi_bus_request(scsi_bus_request),
    .scsi_bus_grant(scsi_bus_grant), .net_bus_request(net_bus_request),
    .net_bus_grant(net_bus_grant), .scsi_config_select(scsi_config_select),
    .net_config_select(net_config_select), .addr_phase(addr_phase),
    .bus_idle(bus_idle), .cbe_in(cbe_in), .scsi_cfg_hit(scsi_cfg_hit),
    .net_cfg_hit(net_cfg_hit), .ad_out(ad_out), .ad_oe(ad_oe),
    .cbe_out(cbe_out), .cbe_oe(cbe_oe), .par_out(par_out), .par_oe(par_oe),
    .scsi_dma_want(scsi_dma_want), .net_dma_want(net_dma_want),
    .scsi_dma_done(scsi_dma_done), .net_event(net_event),
    .scsi_target_abort(scsi_target_abort), .scsi_master_abort(scsi_master_abort),
    .net_target_abort(net_target_abort), .net_master_abort(net_master_abort),
    .dma_running(dma_running), .dma_flushing(dma_flushing),
    .scsi_int_out(scsi_int_out), .scsi_int_oe(scsi_int_oe),
    .net_int_out(net_int_out), .net_int_oe(net_int_oe));
  dfpi_bus_model u_bus (.clk(clk), .reset(reset), .park_en(park_en),
    .scsi_bus_request(scsi_bus_request), .net_bus_request(net_bus_request),
    .scsi_bus_grant(scsi_bus_grant), .net_bus_grant(net_bus_grant),
    .bus_idle(bus_idle));
  always #5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // e holds {pslverr, read data}; tasks start and end between edges
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    {psel, penable} <= 2'h0;
    @(negedge clk);
  endtask
  task automatic cmd(input logic [1:0] c);
    rnd = lfsr(rnd);
    apb(WR, 8'h50, {rnd, rnd[15:2], c}, 33'h0);
  endtask
  task automatic pulse(input logic [5:0] v);
    @(posedge clk) ev <= v;
    @(posedge clk) ev <= 6'h0;
    @(negedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'h1)
    begin
      exp_v = exp_q.pop_front();
      `CHK({pslverr, pwrite ? 32'h0 : prdata}, exp_v)
    end
  end
  // the scenarios need under three hundred cycles; twenty thousand means a hang
  initial
  begin
    #200000;
    mismatches++;
    conclude;
  end
  initial
  begin
    reset = 1'h1;
    ev = 6'h0;
    {psel, penable, pwrite, paddr, pwdata, park_en, addr_phase, cbe_in} = '0;
    {scsi_config_select, net_config_select, scsi_dma_want, net_dma_want} = 4'h0;
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    wt(1);
    // ------------------------------------------------------------
    // reset values, refusals, dma commands
    // ------------------------------------------------------------
    apb(RD, 8'h08, 32'h0, 33'h2);
    apb(RD, 8'h00, 32'h0, 33'h0);
    apb(RD, 8'h04, 32'h0, 33'h0);
    apb(WR, 8'h60, {rnd, rnd}, {1'h1, 32'h0});
    apb(RD, 8'h60, 32'h0, {1'h1, 32'h0});
    apb(WR, 8'h5c, 32'h3, 33'h0);
    @(posedge clk) scsi_dma_want <= 1'h1;
    cmd(2'h2);
    wt(1);
    `CHK({dma_running, scsi_bus_request}, 2'h3)
    // idle must halt a live run, and later keep the abort flag
    cmd(2'h0);
    wt(1);
    `CHK({dma_running, scsi_int_oe}, 2'h0)
    cmd(2'h3);
    cmd(2'h0);
    apb(RD, 8'h54, 32'h0, 33'h4);
    cmd(2'h1);
    apb(RD, 8'h54, 32'h0, 33'h4);
    for (int k = 0; k < 4; k++)
    begin
      cmd(2'h2);
      pulse(6'h8 >> k);
      wt(1);
      `CHK(scsi_int_oe, 1'h0)
      apb(RD, 8'h54, 32'h0, {30'h0, (k < 2 ? 3'h4 : 3'h1)});
      apb(RD, {5'h0, k[1], 2'h0}, 32'h0, 33'h1000 << k[0]);
      apb(WR, {5'h0, k[1], 2'h0}, 32'h3000, 33'h0);
    end
    cmd(2'h2);
    pulse(6'h20);
    `CHK({scsi_int_oe, net_int_oe}, 2'h2)
    apb(RD, 8'h58, 32'h0, 33'h1);
    pulse(6'h10);
    `CHK({scsi_int_oe, net_int_oe, scsi_int_out, net_int_out}, 4'h4)
    apb(WR, 8'h5c, 32'h0, 33'h0);
    `CHK(net_int_oe, 1'h0)
    apb(RD, 8'h58, 32'h0, 33'h2);
    @(posedge clk) park_en <= 1'h1;
    wt(6);
    `CHK({ad_oe, cbe_oe, par_oe, ad_out, cbe_out, par_out}, 40'he0_0000_0000)
    @(posedge clk) net_dma_want <= 1'h1;
    wt(6);
    `CHK({net_bus_request, scsi_bus_request, ad_oe}, 3'h4)
    for (int j = 0; j < 8; j++)
    begin
      @(posedge clk) {net_config_select, scsi_config_select, addr_phase, cbe_in}
        <= {j[0], ~j[0], 1'h1, cmds[4 * j[2:1] +: 4]};
      wt(5);
      `CHK({scsi_cfg_hit, net_cfg_hit}, j < 4 ? {~j[0], j[0]} : 2'h0)
    end
    conclude;
  end
endmodule // dual_function_pci_host_interface_tb_top
`default_nettype wire
